//--- pkg/spi_frame_map.vh
/*
 register offsets, field positions, reset values and mode codes
 for the serial frame-format and slave-abort block
*/
`ifndef SPI_FRAME_MAP_VH
`define SPI_FRAME_MAP_VH
// register byte addresses
`define REG_FORMAT 4'h0
`define REG_CTRL 4'h4
`define REG_STATUS 4'h8
`define REG_IRQ_CLEAR 4'hC
// format register fields
`define FMT_SPARE_HI 7
`define FMT_SPARE_LO 6
`define FMT_IDLE_LOW 5
`define FMT_CAPTURE_EDGE 4
`define FMT_MSB_FIRST 3
`define FMT_SELECT_ON 2
`define FMT_WRITE_COLLISION_FLAG 1
`define FMT_DONE 0
`define FMT_RESET 8'h00
// control register fields
`define CTRL_ON 0
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 1
`define CTRL_IRQ_EN 4
`define CTRL_RESET 8'h00
// mode codes
`define MODE_MASTER 3'h0
`define MODE_SLAVE 3'h1
`define MODE_I2C 3'h2
// status/irq bits
`define ST_DONE 0
`define ST_ABORT 1
`define ST_RESET 2'h0
// frame length in bits
`define FRAME_BITS 8
`endif

//--- rtl/spi_frame_format.v
/*
 frame-format control and slave-abort detection for a serial unit,
 with an Avalon-MM slave (answers with waitrequest low the cycle after
 a request). assumes serial pins are asynchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spi_frame_map.vh"
module spi_frame_format #(
    parameter FRAME_BITS = `FRAME_BITS
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // avalon-mm slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // serial pins
    input wire sckIn,
    output reg sckIdle,
    input wire slaveSelectN,
    output wire selectPinOn,
    output wire msbFirst,
    output wire sampleStrobe,
    // interrupt
    output wire irq
);
    ////////////////////////////////////////////////////////////////////////////
    // local constants
    // pins that cross into the clk_sys domain
    localparam PIN_COUNT = 2;
    // clock pin sits at bit 0, select pin at bit 1
    localparam SCK_PIN = 0;
    localparam SEL_PIN = 1;
    // synchroniser start levels: select idles high, clock low
    localparam [1:0] PIN_IDLE = 2'h2;
    // reset images of the software registers
    localparam [7:0] FMT_INIT = `FMT_RESET;
    localparam [7:0] CTRL_INIT = `CTRL_RESET;
    localparam [1:0] ST_INIT = `ST_RESET;
    // number of sticky status bits
    localparam ST_BITS = 2;

    ////////////////////////////////////////////////////////////////////////////
    // regs: flip-flop state and the combinational read mux output
    // format register fields
    reg [1:0] spareBits;
    reg clockIdleLowSel;
    reg captureEdgeSel;
    reg msbFirstSel;
    reg selectPinOnSel;
    reg writeCollisionFlag;
    reg transferDoneFlag;
    // control register and interrupt enables
    reg [7:0] ctrl;
    reg [1:0] irqEnable;
    // bus answer state
    reg acked;
    // serial side state
    reg sckLast;
    reg [7:0] bitCount;
    // read mux output
    reg [31:0] next_readdata;

    ////////////////////////////////////////////////////////////////////////////
    // combinational nets
    // register images
    wire [7:0] format;
    wire [ST_BITS-1:0] status;
    wire [ST_BITS-1:0] next_status;
    wire [ST_BITS-1:0] statusEvent;
    wire [ST_BITS-1:0] statusClear;
    wire [ST_BITS-1:0] statusSoftSet;
    // synchronised pins
    wire [PIN_COUNT-1:0] pinRaw;
    wire [PIN_COUNT-1:0] pinSync;
    wire sckSync;
    wire selSync;
    // control decode
    wire serialIfOn;
    wire [2:0] modeSel;
    wire irqOn;
    wire slaveMode;
    wire armed;
    // bus decode
    wire request;
    wire wrHit;
    wire rdStart;
    wire formatWrite;
    wire ctrlWrite;
    wire statusWrite;
    wire clearWrite;
    // serial events
    wire sckRise;
    wire sckFall;
    wire captureEdge;
    wire lastBit;
    wire abortEvent;
    wire doneEvent;

    ////////////////////////////////////////////////////////////////////////////
    // avalon-mm handshake
    assign request = read | write;
    // one wait cycle, then answer
    assign waitrequest = request & ~acked;
    // writes land only at the edge where waitrequest is low
    assign wrHit = write & acked;
    // read data is fetched in the wait cycle, stands at the answering edge
    assign rdStart = read & ~acked;

    // ack toggle: high in the answering cycle only
    always @(posedge clk_sys) begin
        if (srst) begin
            acked <= 1'h0;
        end else begin
            acked <= request & ~acked;
        end
    end

    // register write selects
    assign formatWrite = wrHit && address == `REG_FORMAT;
    assign ctrlWrite = wrHit && address == `REG_CTRL;
    assign statusWrite = wrHit && address == `REG_STATUS;
    assign clearWrite = wrHit && address == `REG_IRQ_CLEAR;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops per pin
    assign pinRaw = {slaveSelectN, sckIn};

    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p = p + 1) begin : g_sync
            reg meta;
            reg stable;
            // only the second flop is read by logic
            always @(posedge clk_sys) begin
                if (srst) begin
                    meta <= PIN_IDLE[p];
                    stable <= PIN_IDLE[p];
                end else begin
                    meta <= pinRaw[p];
                    stable <= meta;
                end
            end
            assign pinSync[p] = stable;
        end
    endgenerate

    assign sckSync = pinSync[SCK_PIN];
    assign selSync = pinSync[SEL_PIN];

    // previous clock level for edge detection
    always @(posedge clk_sys) begin
        if (srst) begin
            sckLast <= PIN_IDLE[SCK_PIN];
        end else begin
            sckLast <= sckSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control decode
    assign serialIfOn = ctrl[`CTRL_ON];
    assign modeSel = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign irqOn = ctrl[`CTRL_IRQ_EN];
    assign slaveMode = modeSel == `MODE_SLAVE;

    // format image and field outputs
    assign format = {spareBits, clockIdleLowSel, captureEdgeSel, msbFirstSel,
        selectPinOnSel, writeCollisionFlag, transferDoneFlag};
    assign selectPinOn = selectPinOnSel;
    assign msbFirst = msbFirstSel;
    // abort watch only as slave with unit and select pin on
    assign armed = slaveMode & serialIfOn & selectPinOnSel;

    ////////////////////////////////////////////////////////////////////////////
    // serial edge events
    assign sckRise = sckSync & ~sckLast;
    assign sckFall = ~sckSync & sckLast;
    // idle-high: 0 rise, 1 fall; idle-low: 0 fall, 1 rise
    assign captureEdge = (clockIdleLowSel ^ captureEdgeSel) ? sckFall : sckRise;
    // edges only count while selected
    assign sampleStrobe = armed & ~selSync & captureEdge;
    assign lastBit = bitCount == FRAME_BITS[7:0] - 8'h01;
    assign doneEvent = sampleStrobe & lastBit;
    // select released mid-frame
    assign abortEvent = armed & selSync & (bitCount != 8'h00);

    // clock idle level
    always @(posedge clk_sys) begin
        if (srst) begin
            sckIdle <= ~FMT_INIT[`FMT_IDLE_LOW];
        end else begin
            sckIdle <= ~clockIdleLowSel;
        end
    end

    // bit counter, restarts while select high
    always @(posedge clk_sys) begin
        if (srst) begin
            bitCount <= 8'h00;
        end else if (!armed || selSync || doneEvent) begin
            bitCount <= 8'h00;
        end else if (sampleStrobe) begin
            bitCount <= bitCount + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // format register fields
    // spare bits: storage only
    always @(posedge clk_sys) begin
        if (srst) begin
            spareBits <= FMT_INIT[`FMT_SPARE_HI:`FMT_SPARE_LO];
        end else if (formatWrite) begin
            spareBits <= writedata[`FMT_SPARE_HI:`FMT_SPARE_LO];
        end
    end

    // idle level and capture edge; changing mid-frame is unsafe
    always @(posedge clk_sys) begin
        if (srst) begin
            clockIdleLowSel <= FMT_INIT[`FMT_IDLE_LOW];
            captureEdgeSel <= FMT_INIT[`FMT_CAPTURE_EDGE];
        end else if (formatWrite) begin
            clockIdleLowSel <= writedata[`FMT_IDLE_LOW];
            captureEdgeSel <= writedata[`FMT_CAPTURE_EDGE];
        end
    end

    // shift order and select pin enable
    always @(posedge clk_sys) begin
        if (srst) begin
            msbFirstSel <= FMT_INIT[`FMT_MSB_FIRST];
            selectPinOnSel <= FMT_INIT[`FMT_SELECT_ON];
        end else if (formatWrite) begin
            msbFirstSel <= writedata[`FMT_MSB_FIRST];
            selectPinOnSel <= writedata[`FMT_SELECT_ON];
        end
    end

    // collision bit: kept as plain storage here
    always @(posedge clk_sys) begin
        if (srst) begin
            writeCollisionFlag <= FMT_INIT[`FMT_WRITE_COLLISION_FLAG];
        end else if (formatWrite) begin
            writeCollisionFlag <= writedata[`FMT_WRITE_COLLISION_FLAG];
        end
    end

    // done flag: software may only clear it, a set in the same cycle wins
    always @(posedge clk_sys) begin
        if (srst) begin
            transferDoneFlag <= FMT_INIT[`FMT_DONE];
        end else if (doneEvent || abortEvent) begin
            transferDoneFlag <= 1'h1;
        end else if (formatWrite) begin
            transferDoneFlag <= transferDoneFlag & writedata[`FMT_DONE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register and interrupt enables
    always @(posedge clk_sys) begin
        if (srst) begin
            ctrl <= CTRL_INIT;
        end else if (ctrlWrite) begin
            ctrl <= writedata[7:0];
        end
    end

    // one enable serves both sources
    always @(posedge clk_sys) begin
        if (srst) begin
            irqEnable <= 2'h0;
        end else begin
            irqEnable <= {2{irqOn}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status; abort also sets done
    assign statusEvent = {abortEvent, doneEvent | abortEvent};
    assign statusClear = clearWrite ? writedata[1:0] : 2'h0;
    // software may set abort, never done
    assign statusSoftSet = statusWrite ? {writedata[`ST_ABORT], 1'h0} : 2'h0;
    // set beats clear in the same cycle
    assign next_status = (status & ~statusClear) | statusEvent | statusSoftSet;

    genvar s;
    generate
        for (s = 0; s < ST_BITS; s = s + 1) begin : g_status
            reg flag;
            // one sticky flop per status bit
            always @(posedge clk_sys) begin
                if (srst) begin
                    flag <= ST_INIT[s];
                end else begin
                    flag <= next_status[s];
                end
            end
            assign status[s] = flag;
        end
    endgenerate

    // level interrupt while an enabled bit is set
    assign irq = |(status & irqEnable);

    ////////////////////////////////////////////////////////////////////////////
    // read data mux
    always @* begin
        next_readdata = 32'h00000000;
        case (address)
            `REG_FORMAT: begin
                next_readdata = {24'h000000, format};
            end
            `REG_CTRL: begin
                next_readdata = {24'h000000, ctrl};
            end
            `REG_STATUS: begin
                next_readdata = {30'h00000000, status};
            end
            default: begin
                next_readdata = 32'h00000000;
            end
        endcase
    end

    // read data register, loaded in the wait cycle
    always @(posedge clk_sys) begin
        if (srst) begin
            readdata <= 32'h00000000;
        end else if (rdStart) begin
            readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // notes for users
    // the select pin enable gates abort watching as well as framing
    // the clear register is write-one-to-clear; reads return zero
    // a frame cut short leaves the bit counter at zero for the next one
    // the capture edge is seen about three clocks after the pin moves
    // so the link clock half period must exceed three system clocks
endmodule
`default_nettype wire

//--- verif/spi_frame_format_assertions.sv
/* port checker for the frame-format block
 bound to every instance of the design */
`timescale 1ns/100ps
`default_nettype none
module spi_frame_format_assertions(input wire logic clk_sys, srst, read, write,
    waitrequest, sckIdle, selectPinOn, msbFirst, irq,
    input wire logic [3:0] address, input wire logic [31:0] writedata, readdata);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // write accepted at this edge
    wire logic wrDone = write && !waitrequest;
    wait_first_a: assert property ($rose(read | write) |-> waitrequest) else $error("no wait");
    wait_second_a: assert property ((read | write) && waitrequest |=> !waitrequest)
        else $error("wait too long");
    wait_idle_a: assert property (!(read | write) |-> !waitrequest) else $error("idle wait");
    select_pin_a: assert property (wrDone && address == 4'h0 |=>
        selectPinOn == $past(writedata[2])) else $error("select pin");
    msb_order_a: assert property (wrDone && address == 4'h0 |=>
        msbFirst == $past(writedata[3])) else $error("shift order");
    idle_level_a: assert property (wrDone && address == 4'h0 |=> ##1
        sckIdle == !$past(writedata[5], 2)) else $error("idle level");
    unmapped_zero_a: assert property (read && !waitrequest && address == 4'h2
        |-> readdata == 32'h0) else $error("unmapped read");
    irq_clear_a: assert property (wrDone && address == 4'hC && writedata[1:0] == 2'h3
        |-> ##[1:2] !irq) else $error("irq stuck");
endmodule
bind spi_frame_format spi_frame_format_assertions i_chk(.clk_sys, .srst, .read, .write,
    .waitrequest, .sckIdle, .selectPinOn, .msbFirst, .irq, .address, .writedata, .readdata);
`default_nettype wire

//--- verif/spi_master_model.sv
/* external master: one frame of toggles per go pulse
 clock stands still outside frames */
`timescale 1ns/100ps
`default_nettype none
module spi_master_model(input wire logic go, idleLow, input wire logic [4:0] toggles,
    output logic sckIn, output logic slaveSelectN, output logic busy);
    initial begin
        sckIn = 1'h0;
        slaveSelectN = 1'h1;
        busy = 1'h0;
    end
    // select low, 32 ns clock, select high after toggles
    always @(posedge go) begin
        busy = 1'h1;
        sckIn = !idleLow;
        #3 slaveSelectN = 1'h0;
        #16;
        repeat (toggles) begin
            sckIn = !sckIn;
            #16;
        end
        slaveSelectN = 1'h1;
        busy = 1'h0;
    end
endmodule
`default_nettype wire

//--- verif/spi_frame_format_tb.sv
/* self-checking bench for the frame-format block
 assumes the master model and the bound checker */
`timescale 1ns/100ps
`default_nettype none
module spi_frame_format_tb;
    logic clk_sys = 0, srst = 1, read = 0, write = 0, go = 0, idleLow = 1;
    logic [3:0] address = 0;
    logic [4:0] toggles = 16;
    logic [31:0] writedata = 0, rd;
    wire logic [31:0] readdata;
    wire logic waitrequest, sckIn, sckIdle, slaveSelectN, selectPinOn, msbFirst, sampleStrobe;
    wire logic irq, busy;
    int mismatches = 0, cmp_count = 0, strobes = 0;
    logic strobeLevel = 0;
    initial forever #2 clk_sys = !clk_sys;
    // capture strobe count and pin level at the strobe
    always @(posedge clk_sys) begin
        if (sampleStrobe === 1'h1) begin
            strobes <= strobes + 1;
            strobeLevel <= sckIn;
        end
    end
    spi_frame_format i_spi_frame_format(.clk_sys, .srst, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .sckIn, .sckIdle, .slaveSelectN, .selectPinOn, .msbFirst,
        .sampleStrobe, .irq);
    spi_master_model i_spi_master_model(.go, .idleLow, .toggles, .sckIn, .slaveSelectN, .busy);
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one bus cycle, held until waitrequest low
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (waitrequest === 1'h0) break;
        end
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        if (n == 50) begin
            mismatches++;
            summarize;
        end
    endtask
    task automatic frame(input logic [4:0] t);
        int n;
        toggles <= t;
        go <= 1'h1;
        @(posedge clk_sys);
        go <= 1'h0;
        for (n = 0; busy !== 1'h0 && n < 200; n++) @(posedge clk_sys);
        if (n == 200) begin
            mismatches++;
            summarize;
        end
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        acc(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_format;
        rdchk(4'h0, 32'h0);
        chk(sckIdle, 32'h1);
        acc(1'h1, 4'h0, 32'hFD);
        rdchk(4'h0, 32'hFC);
        chk({msbFirst, selectPinOn, sckIdle}, 32'h6);
        acc(1'h1, 4'h0, 32'h34);
        rdchk(4'h0, 32'h34);
        $display("format done");
    endtask
    task automatic t_abort;
        int base;
        acc(1'h1, 4'h4, 32'h13);
        base = strobes;
        frame(5'h8);
        chk(strobes - base, 32'h4);
        rdchk(4'h8, 32'h3);
        chk(irq, 32'h1);
        acc(1'h1, 4'hC, 32'h3);
        base = strobes;
        frame(5'h10);
        chk(strobes - base, 32'h8);
        chk(strobeLevel, 32'h1);
        rdchk(4'h8, 32'h1);
        acc(1'h1, 4'hC, 32'h3);
        rdchk(4'h8, 32'h0);
        acc(1'h1, 4'h0, 32'h24);
        frame(5'h10);
        chk(strobeLevel, 32'h0);
        rdchk(4'h0, 32'h25);
        acc(1'h1, 4'h0, 32'h24);
        rdchk(4'h0, 32'h24);
        acc(1'h1, 4'hC, 32'h3);
        $display("abort done");
    endtask
    task automatic t_other;
        acc(1'h1, 4'h4, 32'h11);
        frame(5'h8);
        rdchk(4'h8, 32'h0);
        acc(1'h1, 4'h4, 32'h15);
        frame(5'h8);
        rdchk(4'h8, 32'h0);
        acc(1'h1, 4'h8, 32'h2);
        rdchk(4'h8, 32'h2);
        chk(irq, 32'h1);
        acc(1'h1, 4'hC, 32'h3);
        rdchk(4'h2, 32'h0);
        $display("modes done");
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'h0;
        t_format;
        t_abort;
        t_other;
        summarize;
    end
endmodule
`default_nettype wire
